// File: spi_pd_defs.svh
`ifndef SPI_PD_DEFS_SVH
`define SPI_PD_DEFS_SVH

// Instruction codes seen on the serial input.
`define OP_WREN 8'h06
`define OP_WRSR 8'h01
`define OP_DPD 8'hb9
`define OP_SIG 8'hab

// Bit counts that close each sequence.
`define CMD_BITS 6'h08
`define SIG_HDR_BITS 6'h20
`define WRSR_BITS 6'h10

// Status byte layout.
`define NV_MASK 8'h8c
`define GUARD_BIT 7
`define STAT_RESET 8'h00

// Idle levels of cs_n, sck, si, hold_n, wp_n, held by the pin stages in
// reset.
`define PIN_IDLE 5'h13

// Signature reset value; the value is arbitrary.
`define SIG_RESET 8'h5a

// Register offsets.
`define REG_SIG 8'h00
`define REG_STATE 8'h04
`define REG_NVSTAT 8'h08

// Timing: clock rate and delays in ns, then cycle counts.
`define CLK_MHZ 100
`define WAKE_DELAY_NS 1000
`define WRITE_TIME_NS 5000
`define WAKE_CYCLES ((`WAKE_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define WRITE_CYCLES ((`WRITE_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: spi_pd_pkg.sv
`include "spi_pd_defs.svh"

package spi_pd_pkg;

  // Serial sequence position.
  typedef enum logic [5:0] {
    SEQ_IDLE = 6'h01,
    SEQ_CMD = 6'h02,
    SEQ_ADDR = 6'h04,
    SEQ_SIG = 6'h08,
    SEQ_DATA = 6'h10,
    SEQ_SKIP = 6'h20
  } seq_type;

  // Power state of the device.
  typedef enum logic [2:0] {
    PWR_STBY = 3'h1,
    PWR_DOWN = 3'h2,
    PWR_WAKE = 3'h4
  } pwr_type;

  // True when a sequence ended with the expected opcode and exactly the expected bit count.
  function automatic logic seq_match(input logic [7:0] op,
                                     input logic [5:0] cnt,
                                     input logic [7:0] code,
                                     input logic [5:0] bits);
    return (op == code) && (cnt == bits);
  endfunction : seq_match

endpackage : spi_pd_pkg

// File: spi_pin_if.sv
`timescale 1ns/100ps

// Synchronised pin levels and their edges.
interface spi_pin_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic hold_rise;
  modport src (output cs_n, sck, si, hold_n, wp_n, cs_fall, cs_rise,
               sck_rise, sck_fall, hold_rise);
  modport dst (input cs_n, sck, si, hold_n, wp_n, cs_fall, cs_rise,
               sck_rise, sck_fall, hold_rise);
endinterface : spi_pin_if

// File: spi_pin_sync.sv
`timescale 1ns/100ps
`include "spi_pd_defs.svh"

module spi_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pins: cs_n, sck, si, hold_n, wp_n
  input wire logic [4:0] pins_raw,
  // Synchronised view
  spi_pin_if.src pins
);
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] prev_q;

  // Two flops per pin, then one more to find edges. All stages reset to
  // the idle pin levels, so an idle bus shows no edge and no selection
  // once reset ends. A select held low through reset shows up as a fall.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= `PIN_IDLE;
      sync_q <= `PIN_IDLE;
      prev_q <= `PIN_IDLE;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Levels and edges from the settled stages only.
  assign pins.cs_n = sync_q[4];
  assign pins.sck = sync_q[3];
  assign pins.si = sync_q[2];
  assign pins.hold_n = sync_q[1];
  assign pins.wp_n = sync_q[0];
  assign pins.cs_fall = prev_q[4] & ~sync_q[4];
  assign pins.cs_rise = ~prev_q[4] & sync_q[4];
  assign pins.sck_rise = ~prev_q[3] & sync_q[3];
  assign pins.sck_fall = prev_q[3] & ~sync_q[3];
  assign pins.hold_rise = ~prev_q[1] & sync_q[1];
endmodule : spi_pin_sync

// File: spi_delay_timer.sv
`timescale 1ns/100ps

module spi_delay_timer #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start and length
  input wire logic start,
  input wire logic [WIDTH-1:0] count,
  // State
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;

  // A start while running is ignored, so a cycle always runs out whole.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (start && cnt_q == '0) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Done marks the last busy cycle.
  assign busy = (cnt_q != '0);
  assign done = (cnt_q == WIDTH'(1));
endmodule : spi_delay_timer

// File: spi_pd_hold_port.sv
`timescale 1ns/100ps
`include "spi_pd_defs.svh"

// Overview of operation
// - In power-down, read and write commands are ignored; the array stays safe.
// - Power-down starts only if select rises right after eight instruction bits.
// - In power-down only the signature command is taken; it wakes the device.
// - Power loss ends power-down; power-up always starts in standby.
// - Signature command works in standby, except during a write cycle.
// - Signature read is opcode, 24 dummy bits, then 8 signature bits out.
// - Raising select after the signature ends the sequence; back to standby.
// - Further clocks repeat the signature until select rises.
// - Select rising after the 8-bit wake opcode still wakes after wake_delay.
// - Low select selects; high deselects, but a running write cycle completes.
// - Serial output floats whenever the device is deselected.
// - Select rising after a valid write sequence starts the timed write.
// - Input sampled on clock rise; output changes after clock fall.
// - Guard pin low with guard enable set refuses status writes.
// - With guard enable clear, the guard pin has no effect.
// - A started write cycle is not disturbed by the guard pin.
// - Pause low with clock low pauses; with clock high, at next fall.
// - While paused, serial pins are ignored; host keeps select low.
// - Pause low at any time floats the serial output.
module spi_pd_hold_port
  import spi_pd_pkg::*;
#(
  parameter logic [15:0] WAKE_CYCLES = 16'(`WAKE_CYCLES),
  parameter logic [15:0] WRITE_CYCLES = 16'(`WRITE_CYCLES)
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Serial pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);
  localparam int WAKE_LIM = int'(WAKE_CYCLES) + 2;

  spi_pin_if pins ();
  seq_type seq_q;
  pwr_type pwr_q;
  logic [5:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] op_q;
  logic [7:0] data_q;
  logic [7:0] pend_q;
  logic [7:0] nv_q;
  logic [7:0] sig_q;
  logic [2:0] idx_q;
  logic drive_q;
  logic paused_q;
  logic wel_q;
  logic sel;
  logic sck_r;
  logic sck_f;
  logic [7:0] in_byte;
  logic guard_on;
  logic wr_go;
  logic wake_go;
  logic wbusy;
  logic wdone;
  logic wkbusy;
  logic wkdone;

  spi_pin_sync u_sync (
    .clk(REF_CLK),
    .rst(SRST),
    .pins_raw({CS_N, SCK, SI, HOLD_N, WP_N}),
    .pins(pins.src)
  );

  // Self-timed write cycle; runs on whatever select does meanwhile.
  spi_delay_timer #(.WIDTH(16)) u_write (
    .clk(REF_CLK),
    .rst(SRST),
    .start(wr_go),
    .count(WRITE_CYCLES),
    .busy(wbusy),
    .done(wdone)
  );

  // Release delay between wake command and standby.
  spi_delay_timer #(.WIDTH(16)) u_wake (
    .clk(REF_CLK),
    .rst(SRST),
    .start(wake_go),
    .count(WAKE_CYCLES),
    .busy(wkbusy),
    .done(wkdone)
  );

  // Serial clock edges count only when selected and not paused.
  assign sel = ~pins.cs_n;
  assign sck_r = pins.sck_rise & sel & ~paused_q & pins.hold_n;
  assign sck_f = pins.sck_fall & sel & ~paused_q & pins.hold_n;
  assign in_byte = {shift_q[6:0], pins.si};
  assign guard_on = ~pins.wp_n & nv_q[`GUARD_BIT];

  // Write cycle starts on select rising after a full, permitted write.
  assign wr_go = pins.cs_rise & (pwr_q == PWR_STBY) & ~wbusy & wel_q
    & seq_match(op_q, cnt_q, `OP_WRSR, `WRSR_BITS) & ~guard_on;
  // Wake starts on select rising any time after the 8-bit wake opcode.
  assign wake_go = pins.cs_rise & (pwr_q == PWR_DOWN)
    & (op_q == `OP_SIG) & (cnt_q >= `CMD_BITS);

  // Pause: lowering while the clock is low takes effect at once; lowering
  // while it is high waits for the clock to go low. Resume needs a pause
  // rise while the clock is low, so a late rise leaves the device paused.
  always_ff @(posedge REF_CLK) begin
    if (SRST || !sel) begin
      paused_q <= 1'b0;
    end else if (!paused_q) begin
      if (!pins.hold_n && !pins.sck && seq_q != SEQ_IDLE) begin
        paused_q <= 1'b1;
      end
    end else if (pins.hold_rise && !pins.sck) begin
      paused_q <= 1'b0;
    end
  end

  // Sequence tracking; input bits are taken on the clock rise.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      seq_q <= SEQ_IDLE;
      cnt_q <= 6'h00;
      shift_q <= 8'h00;
      op_q <= 8'h00;
      data_q <= 8'h00;
    end else if (pins.cs_fall) begin
      seq_q <= SEQ_CMD;
      cnt_q <= 6'h00;
    end else if (!sel) begin
      seq_q <= SEQ_IDLE;
    end else if (sck_r) begin
      shift_q <= in_byte;
      if (cnt_q != 6'h3f) begin
        cnt_q <= cnt_q + 6'h01;
      end
      case (seq_q)
        SEQ_CMD: begin
          if (cnt_q == `CMD_BITS - 6'h01) begin
            op_q <= in_byte;
            if (in_byte == `OP_SIG && pwr_q != PWR_WAKE && !wbusy) begin
              seq_q <= SEQ_ADDR;
            end else if (in_byte == `OP_WRSR && pwr_q == PWR_STBY) begin
              seq_q <= SEQ_DATA;
            end else begin
              seq_q <= SEQ_SKIP;
            end
          end
        end
        SEQ_ADDR: begin
          if (cnt_q == `SIG_HDR_BITS - 6'h01) begin
            seq_q <= SEQ_SIG;
          end
        end
        SEQ_DATA: begin
          if (cnt_q == `WRSR_BITS - 6'h01) begin
            data_q <= in_byte;
          end
        end
        SEQ_SIG, SEQ_SKIP, SEQ_IDLE: begin
          seq_q <= seq_q;
        end
        default: begin
          seq_q <= SEQ_SKIP;
        end
      endcase
    end
  end

  // Signature bits leave on clock falls, MSB first, wrapping so further
  // clocks repeat the byte until select rises.
  always_ff @(posedge REF_CLK) begin
    if (SRST || !sel) begin
      SO <= 1'b0;
      idx_q <= 3'h7;
      drive_q <= 1'b0;
    end else if (seq_q == SEQ_SIG && sck_f) begin
      SO <= sig_q[idx_q];
      idx_q <= idx_q - 3'h1;
      drive_q <= 1'b1;
    end
  end

  // Output enable drops while deselected, paused or pause is low.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      SO_OE <= 1'b0;
    end else begin
      SO_OE <= sel & drive_q & pins.hold_n & ~paused_q;
    end
  end

  // Power state; reset stands for power-up and always gives standby.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pwr_q <= PWR_STBY;
    end else begin
      case (pwr_q)
        PWR_STBY: begin
          if (pins.cs_rise && !wbusy
              && seq_match(op_q, cnt_q, `OP_DPD, `CMD_BITS)) begin
            pwr_q <= PWR_DOWN;
          end
        end
        PWR_DOWN: begin
          if (wake_go) begin
            pwr_q <= PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          if (wkdone) begin
            pwr_q <= PWR_STBY;
          end
        end
        default: begin
          pwr_q <= PWR_STBY;
        end
      endcase
    end
  end

  // Write enable latch; only standby may set it, and a status write or a
  // refused attempt clears it.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      wel_q <= 1'b0;
    end else if (pins.cs_rise && pwr_q == PWR_STBY && !wbusy) begin
      if (seq_match(op_q, cnt_q, `OP_WREN, `CMD_BITS)) begin
        wel_q <= 1'b1;
      end else if (seq_match(op_q, cnt_q, `OP_WRSR, `WRSR_BITS)) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Status byte: the value is captured at the start and applied at the
  // end, so the guard pin moving mid-cycle changes nothing.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pend_q <= `STAT_RESET;
      nv_q <= `STAT_RESET;
    end else begin
      if (wr_go) begin
        pend_q <= data_q;
      end
      if (wdone) begin
        nv_q <= (nv_q & ~`NV_MASK) | (pend_q & `NV_MASK);
      end
    end
  end

  // Register port: signature byte is writable, the rest read only.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sig_q <= `SIG_RESET;
    end else if (REG_WR && REG_ADDR == `REG_SIG) begin
      sig_q <= REG_WDATA;
    end
  end

  // Read data stand for one cycle only; unmapped offsets read zero.
  always_ff @(posedge REF_CLK) begin
    if (SRST || !REG_RD) begin
      REG_RDATA <= 8'h00;
    end else begin
      case (REG_ADDR)
        `REG_SIG: REG_RDATA <= sig_q;
        `REG_STATE: REG_RDATA <= {2'h0, wel_q, paused_q, sel, wbusy,
                                  pwr_q == PWR_WAKE, pwr_q == PWR_DOWN};
        `REG_NVSTAT: REG_RDATA <= nv_q;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Checks are off while reset is high, since reset stands for power-up.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_pd_entry: assert property (pins.cs_rise && pwr_q == PWR_STBY && !wbusy
    && cnt_q == `CMD_BITS && op_q == `OP_DPD |=> pwr_q == PWR_DOWN)
    else $error("power-down not entered");
  a_pd_no_wel: assert property (pwr_q != PWR_STBY |=> !$rose(wel_q))
    else $error("write enable set out of standby");
  a_sig_wake: assert property (wake_go |=> pwr_q == PWR_WAKE)
    else $error("signature command did not wake");
  a_wake_time: assert property ($rose(pwr_q == PWR_WAKE) |->
    (pwr_q == PWR_WAKE)[*2] ##[1:WAKE_LIM] pwr_q == PWR_STBY)
    else $error("wake delay wrong");
  a_so_desel: assert property (!sel |=> !SO_OE)
    else $error("output driven while deselected");
  a_so_hold: assert property (!pins.hold_n |=> !SO_OE)
    else $error("output driven while pause low");
  a_guard_block: assert property (pins.cs_rise && guard_on && wel_q
    && !wbusy |=> !wbusy)
    else $error("guarded status write started");
  a_guard_off: assert property (pins.cs_rise && !nv_q[`GUARD_BIT] && wel_q
    && !wbusy && pwr_q == PWR_STBY && cnt_q == `WRSR_BITS
    && op_q == `OP_WRSR |=> wbusy)
    else $error("status write did not start");
  a_write_keep: assert property (wbusy && !wdone |=> wbusy)
    else $error("write cycle cut short");
  a_sig_busy: assert property (seq_q == SEQ_CMD && sck_r && wbusy
    |=> seq_q != SEQ_ADDR)
    else $error("signature taken during write");
  a_pause_hold: assert property (paused_q && sel |=> $stable(cnt_q))
    else $error("bits taken while paused");
  a_sig_repeat: assert property (seq_q == SEQ_SIG && sck_f && sel
    |=> SO == sig_q[$past(idx_q)] && idx_q == $past(idx_q) - 3'h1)
    else $error("signature bit wrong");
  a_so_edge: assert property (sel && !sck_f |=> $stable(SO))
    else $error("serial output moved without a clock fall");
  a_pause_quiet: assert property (paused_q |=> !SO_OE)
    else $error("output driven while paused");
  a_down_nowrite: assert property (pwr_q != PWR_STBY && !wbusy
    |=> !wbusy)
    else $error("write cycle started out of standby");
  a_desel_idle: assert property (!sel |=> seq_q == SEQ_IDLE)
    else $error("sequence kept after deselect");
  a_sig_first: assert property (seq_q == SEQ_ADDR && sck_r
    && cnt_q == `SIG_HDR_BITS - 6'h01 |=> seq_q == SEQ_SIG
    && idx_q == 3'h7)
    else $error("signature did not start after dummy bits");

  // Scenarios that the bench is meant to reach at least once.
  c_wake: cover property (pwr_q == PWR_DOWN ##1 pwr_q == PWR_WAKE);
  c_repeat: cover property (drive_q && idx_q == 3'h7 && seq_q == SEQ_SIG
    && sck_f);
  c_pause: cover property ($rose(paused_q) ##[1:200] $fell(paused_q));
  c_status_write: cover property (wdone);
  c_busy_sig: cover property (seq_q == SEQ_CMD && sck_r && wbusy);
endmodule : spi_pd_hold_port

// File: spi_host_model.sv
`timescale 1ns/100ps

// Host bus master that owns select, serial clock, serial data and pause.
module spi_host_model (
  // Timing reference
  input wire logic clk,
  // Host-driven pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  // Device data line as seen on the wire
  input wire logic so_line
);
  // Idle levels: deselected, clock low, pause released.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Half a serial clock period is 8 REF_CLK cycles, so 160 ns per bit.
  task automatic half();
    repeat (8) @(posedge clk);
  endtask : half

  // Every sequence, the first one too, begins with a falling select.
  task automatic select();
    @(posedge clk);
    cs_n <= 1'b0;
    half();
  endtask : select

  // Data is toggled after release so a stale level never looks driven.
  task automatic deselect();
    half();
    cs_n <= 1'b1;
    si <= ~si;
    half();
  endtask : deselect

  // Shifts n bits MSB first and samples the device line on each rise.
  task automatic shift(input logic [31:0] dout, input int n,
                       output logic [31:0] din);
    din = 32'h0;
    for (int i = 0; i < n; i++) begin
      si <= dout[n-1-i];
      half();
      sck <= 1'b1;
      din = {din[30:0], so_line};
      half();
      sck <= 1'b0;
    end
  endtask : shift

  // Pause and resume move only in the middle of a low clock phase.
  task automatic pause();
    half();
    hold_n <= 1'b0;
    half();
  endtask : pause

  task automatic resume();
    half();
    hold_n <= 1'b1;
    half();
  endtask : resume
endmodule : spi_host_model

// File: tb.sv
`timescale 1ns/100ps
`include "spi_pd_defs.svh"

module tb;
  // Short delays keep the run brief; the write cycle is long enough that
  // a whole opcode can be clocked in while it runs.
  localparam logic [15:0] WAKE_N = 16'h0010;
  localparam logic [15:0] WRITE_N = 16'h0100;
  logic ref_clk, srst, wp_n, wr_stb, rd_stb, so, so_oe, so_line;
  logic cs_n, sck, si, hold_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [31:0] r;
  int err_total, num_checks;

  // The output floats unless the device enables it.
  assign so_line = so_oe ? so : 1'bz;

  spi_pd_hold_port #(.WAKE_CYCLES(WAKE_N), .WRITE_CYCLES(WRITE_N))
  u_spi_pd_hold_port (.REF_CLK(ref_clk), .SRST(srst), .CS_N(cs_n),
    .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n), .SO(so),
    .SO_OE(so_oe), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(wr_stb), .REG_RD(rd_stb), .REG_RDATA(reg_rdata));

  spi_host_model u_spi_host_model (.clk(ref_clk), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .so_line(so_line));

  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Register port: one-cycle strobes, read data in the following cycle.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_rd

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] m,
                            input logic [7:0] e);
    logic [7:0] v;
    reg_rd(a, v);
    check(v & m, e);
  endtask : expect_reg

  // Polls the state register; running out of tries ends the run.
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    int k;
    for (k = 0; k < 200; k++) begin
      reg_rd(`REG_STATE, v);
      if ((v & m) === e) break;
    end
    check(v & m, e);
    if (k == 200) summarize();
  endtask : poll

  task automatic sh(input logic [31:0] v, input int n);
    u_spi_host_model.shift(v, n, r);
  endtask : sh

  task automatic cmd(input logic [31:0] v, input int n);
    u_spi_host_model.select();
    sh(v, n);
    u_spi_host_model.deselect();
  endtask : cmd

  task automatic wrsr(input logic [7:0] v);
    cmd({24'h0, `OP_WREN}, 8);
    cmd({16'h0, `OP_WRSR, v}, 16);
  endtask : wrsr

  task automatic t_reset();
    expect_reg(`REG_STATE, 8'hff, 8'h00);
    expect_reg(`REG_NVSTAT, 8'hff, `STAT_RESET);
    expect_reg(`REG_SIG, 8'hff, `SIG_RESET);
    expect_reg(8'h0c, 8'hff, 8'h00);
    check(so_oe, 1'b0);
    reg_wr(`REG_STATE, 8'hff);
    expect_reg(`REG_STATE, 8'hff, 8'h00);
  endtask : t_reset

  task automatic t_sig();
    reg_wr(`REG_SIG, 8'h3c);
    u_spi_host_model.select();
    sh({`OP_SIG, 24'h0}, 32);
    sh(32'h0, 16);
    check(r[15:0], 16'h3c3c);
    check(so_oe, 1'b1);
    expect_reg(`REG_STATE, 8'h08, 8'h08);
    u_spi_host_model.deselect();
    check(so_oe, 1'b0);
    poll(8'h0b, 8'h00);
  endtask : t_sig

  task automatic t_pd();
    cmd({23'h0, `OP_DPD, 1'b0}, 9);
    expect_reg(`REG_STATE, 8'h01, 8'h00);
    cmd({24'h0, `OP_DPD}, 8);
    expect_reg(`REG_STATE, 8'h01, 8'h01);
    wrsr(8'h8c);
    expect_reg(`REG_STATE, 8'h24, 8'h00);
    expect_reg(`REG_NVSTAT, 8'hff, 8'h00);
    cmd({24'h0, `OP_SIG}, 8);
    expect_reg(`REG_STATE, 8'h03, 8'h02);
    poll(8'h03, 8'h00);
    cmd({24'h0, `OP_DPD}, 8);
    u_spi_host_model.select();
    sh({`OP_SIG, 24'h0}, 32);
    sh(32'h0, 8);
    check(r[7:0], 8'h3c);
    u_spi_host_model.deselect();
    poll(8'h03, 8'h00);
    // Power loss in the middle of power-down leaves standby behind.
    cmd({24'h0, `OP_DPD}, 8);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    expect_reg(`REG_STATE, 8'h03, 8'h00);
  endtask : t_pd

  task automatic t_status();
    @(posedge ref_clk);
    wp_n <= 1'b0;
    wrsr(8'h8c);
    expect_reg(`REG_STATE, 8'h04, 8'h04);
    // A signature command clocked in while the write runs is skipped.
    u_spi_host_model.select();
    sh({`OP_SIG, 24'h0}, 32);
    sh(32'h0, 8);
    check(r[7:0], 8'hzz);
    check(so_oe, 1'b0);
    u_spi_host_model.deselect();
    poll(8'h04, 8'h00);
    expect_reg(`REG_NVSTAT, 8'hff, 8'h8c);
    @(posedge ref_clk);
    wp_n <= 1'b1;
    wrsr(8'h84);
    @(posedge ref_clk);
    wp_n <= 1'b0;
    expect_reg(`REG_STATE, 8'h04, 8'h04);
    poll(8'h04, 8'h00);
    expect_reg(`REG_NVSTAT, 8'hff, 8'h84);
    wrsr(8'h00);
    poll(8'h04, 8'h00);
    expect_reg(`REG_NVSTAT, 8'hff, 8'h84);
    expect_reg(`REG_STATE, 8'h20, 8'h00);
    @(posedge ref_clk);
    wp_n <= 1'b1;
    wrsr(8'h00);
    poll(8'h04, 8'h00);
    expect_reg(`REG_NVSTAT, 8'hff, 8'h00);
  endtask : t_status

  task automatic t_hold();
    u_spi_host_model.select();
    sh({16'h0, `OP_SIG, 8'h00}, 16);
    u_spi_host_model.pause();
    expect_reg(`REG_STATE, 8'h10, 8'h10);
    sh(32'hf, 4);
    u_spi_host_model.resume();
    sh(32'h0, 16);
    sh(32'h0, 8);
    check(r[7:0], `SIG_RESET);
    u_spi_host_model.pause();
    check(so_oe, 1'b0);
    u_spi_host_model.resume();
    sh(32'h0, 8);
    check(r[7:0], `SIG_RESET);
    u_spi_host_model.deselect();
    poll(8'h1b, 8'h00);
  endtask : t_hold

  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_sig();
    t_pd();
    t_status();
    t_hold();
    summarize();
  end
endmodule : tb
